/* drive_object_dictionary.v */
// drive object dictionary: fieldbus object access, parameter update timing
// assumes the master presents one request per cycle at most
//
// Notes on behaviour
// - probe two select is 8-bit read/write; 0 zero-speed, 1 timing output.
// - a new probe two select applies only when permission bit 8 rises.
// - a 16-bit read-only unmapped object holds the firmware cpu number.
// - a 16-bit read-only object holds the firmware version, major byte high.
// - working values vanish with power while stored values survive it.
// - at power-up all stored values are copied to working memory and applied.
// - master writes change working memory only; a commit command stores them.
// - an aborted storage write raises the storage alarm with code 41h.
// - class A parameters apply as soon as the write is accepted.
// - class B parameters apply once motion has stopped.
// - class C values apply after a configuration action or a power cycle.
// - class D parameters apply only after a power cycle.
// - rx mapping one: count 3 (0 to 16), three default entries, rest zero.
// - read-only objects can only be read; read/write objects both ways.
// - probe one select uses the same coding and applies when bit 0 rises.
`timescale 1ns/1ps
`include "drive_od_consts.vh"

module drive_object_dictionary #(
  parameter DEVICE_PROFILE_TYPE = 32'h0000_0000, // arbitrary value
  parameter MAKER_CODE = 32'h0000_0001, // arbitrary value
  parameter PART_CODE = 32'h0000_0002, // arbitrary value
  parameter HARDWARE_REVISION = 32'h0000_0003, // arbitrary value
  parameter [15:0] FIRMWARE_CPU_INDEX = 16'h0001, // arbitrary value
  parameter [15:0] FIRMWARE_VERSION = 16'h0100,
  parameter NV_HOLD_CYCLES = `NV_HOLD_CYCLES,
  parameter NV_BYTE_CYCLES = `NV_BYTE_CYCLES
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_req_valid,
  input wire i_req_write,
  input wire [15:0] i_req_index,
  input wire [7:0] i_req_sub,
  input wire [31:0] i_req_wdata,
  input wire [15:0] i_probe_function,
  input wire i_motion_stopped,
  input wire i_config_exec,
  input wire i_ctrl_supply_loss,
  output reg o_rsp_valid,
  output reg o_rsp_abort,
  output reg [31:0] o_rsp_rdata,
  output reg o_probe1_trigger_sel,
  output reg o_probe2_trigger_sel,
  output reg o_push_current_sel,
  output reg [1:0] o_wrap_mode,
  output reg [7:0] o_class_c_value,
  output reg [7:0] o_main_power_mode,
  output reg [4:0] o_rx_map_count,
  output reg o_storage_alarm,
  output reg [7:0] o_alarm_code,
  output reg o_nv_busy
);
  // working memory (lost with power)
  reg [7:0] probe1_sel_q;
  reg [7:0] probe2_sel_q;
  reg [7:0] push_sel_q;
  reg [7:0] wrap_mode_q;
  reg [7:0] class_c_q;
  reg [7:0] main_power_q;
  reg [4:0] rx_count_q;
  reg [31:0] rx_entry_q [0:15];
  reg [7:0] error_summary_q;
  reg booting_q;
  reg wrap_pending_q;
  reg [15:0] probe_func_prev_q;
  integer i;

  wire [8*`NV_SLOTS-1:0] nv_bytes;
  wire [8*`NV_SLOTS-1:0] ram_bytes;
  wire nv_busy;
  wire nv_abort;

  // decode results
  reg known;
  reg writable;
  reg range_ok;
  reg [31:0] rd_data;
  wire [4:0] entry_sel_wide;
  wire [3:0] entry_sel;
  wire wr_ok;
  wire commit_go;
  wire probe1_arm;
  wire probe2_arm;

  function fits;
    input [31:0] value;
    input [31:0] limit;
    begin
      fits = (value <= limit);
    end
  endfunction

  function [7:0] nv_slot;
    input [8*`NV_SLOTS-1:0] bytes;
    input integer slot;
    begin
      nv_slot = bytes[8*slot +: 8];
    end
  endfunction

  assign ram_bytes = {main_power_q, class_c_q, wrap_mode_q, push_sel_q,
                      probe2_sel_q, probe1_sel_q};
  assign entry_sel_wide = i_req_sub[4:0] - 5'd1;
  assign entry_sel = entry_sel_wide[3:0];

  always @* begin
    known = 1'b0;
    writable = 1'b0;
    range_ok = 1'b0;
    rd_data = 32'h0;
    case (i_req_index)
      `IDX_DEVICE_PROFILE_TYPE: begin
        known = (i_req_sub == 8'h00);
        rd_data = DEVICE_PROFILE_TYPE;
      end
      `IDX_ERROR_SUMMARY: begin
        known = (i_req_sub == 8'h00);
        rd_data = {24'h0, error_summary_q};
      end
      `IDX_IDENTITY: begin
        known = (i_req_sub <= `SUB_IDENTITY_LAST);
        case (i_req_sub)
          8'h00: rd_data = `IDENTITY_ENTRY_COUNT;
          8'h01: rd_data = MAKER_CODE;
          8'h02: rd_data = PART_CODE;
          8'h03: rd_data = HARDWARE_REVISION;
          default: rd_data = `UNIT_SERIAL;
        endcase
      end
      `IDX_RX_MAP: begin
        known = (i_req_sub <= `SUB_RX_MAP_LAST);
        writable = 1'b1;
        if (i_req_sub == 8'h00) begin
          rd_data = {27'h0, rx_count_q};
          range_ok = fits(i_req_wdata, `RANGE_RX_COUNT_MAX);
        end else begin
          rd_data = rx_entry_q[entry_sel];
          range_ok = 1'b1;
        end
      end
      `IDX_COMMIT_PARAMS: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        range_ok = (i_req_wdata == `COMMIT_CODE) && !nv_busy;
      end
      `IDX_PUSH_CURRENT_SEL: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        rd_data = {24'h0, push_sel_q};
        range_ok = fits(i_req_wdata, `RANGE_SEL_MAX);
      end
      `IDX_WRAP_MODE: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        rd_data = {24'h0, wrap_mode_q};
        range_ok = fits(i_req_wdata, `RANGE_WRAP_MAX);
      end
      `IDX_CLASS_C_VALUE: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        rd_data = {24'h0, class_c_q};
        range_ok = fits(i_req_wdata, `RANGE_BYTE_MAX);
      end
      `IDX_MAIN_POWER_MODE: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        rd_data = {24'h0, main_power_q};
        range_ok = fits(i_req_wdata, `RANGE_SEL_MAX) ||
                   (i_req_wdata[7:0] == `MAIN_POWER_AUTO &&
                    i_req_wdata[31:8] == 24'h0);
      end
      `IDX_PROBE_ONE_SEL: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        rd_data = {24'h0, probe1_sel_q};
        range_ok = fits(i_req_wdata, `RANGE_SEL_MAX);
      end
      `IDX_PROBE_TWO_SEL: begin
        known = (i_req_sub == 8'h00);
        writable = 1'b1;
        rd_data = {24'h0, probe2_sel_q};
        range_ok = fits(i_req_wdata, `RANGE_SEL_MAX);
      end
      `IDX_FIRMWARE_CPU_INDEX: begin
        known = (i_req_sub == 8'h00);
        rd_data = {16'h0, FIRMWARE_CPU_INDEX};
      end
      `IDX_FIRMWARE_VERSION: begin
        known = (i_req_sub == 8'h00);
        rd_data = {16'h0, FIRMWARE_VERSION};
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // writes land only while not restoring from storage
  assign wr_ok = i_req_valid && i_req_write && known && writable &&
                 range_ok && !booting_q;
  assign commit_go = wr_ok && (i_req_index == `IDX_COMMIT_PARAMS);
  assign probe1_arm = i_probe_function[0] && !probe_func_prev_q[0];
  assign probe2_arm = i_probe_function[8] && !probe_func_prev_q[8];

  param_nv_store #(
    .HOLD_CYCLES(NV_HOLD_CYCLES),
    .BYTE_CYCLES(NV_BYTE_CYCLES)
  ) u_nv (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_commit(commit_go),
    .i_ram_bytes(ram_bytes),
    .i_supply_loss(i_ctrl_supply_loss),
    .o_nv_bytes(nv_bytes),
    .o_busy(nv_busy),
    .o_abort(nv_abort)
  );

  // access answer, one cycle after the request
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_abort <= 1'b0;
      o_rsp_rdata <= 32'h0;
    end else begin
      o_rsp_valid <= i_req_valid;
      o_rsp_abort <= i_req_valid && !wr_ok &&
                     (!known || i_req_write || booting_q);
      o_rsp_rdata <= (i_req_valid && !i_req_write && known) ?
                     rd_data : 32'h0;
    end
  end

  // working memory; restored from storage on the first cycle after reset
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      booting_q <= 1'b1;
      probe1_sel_q <= 8'h00;
      probe2_sel_q <= 8'h00;
      push_sel_q <= 8'h00;
      wrap_mode_q <= 8'h00;
      class_c_q <= 8'h00;
      main_power_q <= `MAIN_POWER_AUTO;
    end else if (booting_q) begin
      booting_q <= 1'b0;
      probe1_sel_q <= nv_slot(nv_bytes, `NV_SLOT_PROBE_ONE);
      probe2_sel_q <= nv_slot(nv_bytes, `NV_SLOT_PROBE_TWO);
      push_sel_q <= nv_slot(nv_bytes, `NV_SLOT_PUSH);
      wrap_mode_q <= nv_slot(nv_bytes, `NV_SLOT_WRAP);
      class_c_q <= nv_slot(nv_bytes, `NV_SLOT_CLASS_C);
      main_power_q <= nv_slot(nv_bytes, `NV_SLOT_MAIN_POWER);
    end else if (wr_ok) begin
      case (i_req_index)
        `IDX_PROBE_ONE_SEL: probe1_sel_q <= i_req_wdata[7:0];
        `IDX_PROBE_TWO_SEL: probe2_sel_q <= i_req_wdata[7:0];
        `IDX_PUSH_CURRENT_SEL: push_sel_q <= i_req_wdata[7:0];
        `IDX_WRAP_MODE: wrap_mode_q <= i_req_wdata[7:0];
        `IDX_CLASS_C_VALUE: class_c_q <= i_req_wdata[7:0];
        `IDX_MAIN_POWER_MODE: main_power_q <= i_req_wdata[7:0];
        default: booting_q <= 1'b0;
      endcase
    end
  end

  // receive mapping one (not stored, defaults at power-up)
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_count_q <= `RX_MAP_COUNT_RESET;
      for (i = 0; i < 16; i = i + 1)
        rx_entry_q[i] <= `RX_MAP_ENTRY_REST_RESET;
      rx_entry_q[0] <= `RX_MAP_ENTRY1_RESET;
      rx_entry_q[1] <= `RX_MAP_ENTRY2_RESET;
      rx_entry_q[2] <= `RX_MAP_ENTRY3_RESET;
    end else if (wr_ok && i_req_index == `IDX_RX_MAP) begin
      if (i_req_sub == 8'h00)
        rx_count_q <= i_req_wdata[4:0];
      else
        rx_entry_q[entry_sel] <= i_req_wdata;
    end
  end

  // applied values by update class
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      probe_func_prev_q <= 16'h0;
      wrap_pending_q <= 1'b0;
      o_probe1_trigger_sel <= 1'b0;
      o_probe2_trigger_sel <= 1'b0;
      o_push_current_sel <= 1'b0;
      o_wrap_mode <= 2'h0;
      o_class_c_value <= 8'h00;
      o_main_power_mode <= `MAIN_POWER_AUTO;
      o_rx_map_count <= `RX_MAP_COUNT_RESET;
    end else if (booting_q) begin
      probe_func_prev_q <= i_probe_function;
      wrap_pending_q <= 1'b0;
      o_probe1_trigger_sel <= nv_bytes[8*`NV_SLOT_PROBE_ONE];
      o_probe2_trigger_sel <= nv_bytes[8*`NV_SLOT_PROBE_TWO];
      o_push_current_sel <= nv_bytes[8*`NV_SLOT_PUSH];
      o_wrap_mode <= nv_bytes[8*`NV_SLOT_WRAP +: 2];
      o_class_c_value <= nv_slot(nv_bytes, `NV_SLOT_CLASS_C);
      o_main_power_mode <= nv_slot(nv_bytes, `NV_SLOT_MAIN_POWER);
    end else begin
      probe_func_prev_q <= i_probe_function;
      o_rx_map_count <= rx_count_q;
      if (probe1_arm)
        o_probe1_trigger_sel <= probe1_sel_q[0];
      if (probe2_arm)
        o_probe2_trigger_sel <= probe2_sel_q[0];
      if (wr_ok && i_req_index == `IDX_PUSH_CURRENT_SEL)
        o_push_current_sel <= i_req_wdata[0];
      // class b: a write while moving waits for the stop
      if (wr_ok && i_req_index == `IDX_WRAP_MODE)
        wrap_pending_q <= 1'b1;
      else if (wrap_pending_q && i_motion_stopped) begin
        wrap_pending_q <= 1'b0;
        o_wrap_mode <= wrap_mode_q[1:0];
      end
      if (i_config_exec)
        o_class_c_value <= class_c_q;
    end
  end

  // storage alarm and error summary; stays until power-up
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_storage_alarm <= 1'b0;
      o_alarm_code <= 8'h00;
      error_summary_q <= 8'h00;
      o_nv_busy <= 1'b0;
    end else begin
      o_nv_busy <= nv_busy;
      if (nv_abort) begin
        o_storage_alarm <= 1'b1;
        o_alarm_code <= `ALARM_CODE_STORAGE;
        error_summary_q[`ERR_BIT_GENERIC] <= 1'b1;
      end
    end
  end
endmodule // drive_object_dictionary

/* drive_od_checker_asserts.sv */
// checker: answer timing, refusals, update classes, storage alarm
// assumes it is bound to the dictionary; one clock, sync reset
`timescale 1ns/1ps
module drive_od_checker (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_req_valid,
  input wire i_req_write,
  input wire [15:0] i_req_index,
  input wire [7:0] i_req_sub,
  input wire [31:0] i_req_wdata,
  input wire [15:0] i_probe_function,
  input wire i_motion_stopped,
  input wire i_config_exec,
  input wire i_ctrl_supply_loss,
  input wire o_rsp_valid,
  input wire o_rsp_abort,
  input wire [31:0] o_rsp_rdata,
  input wire o_probe1_trigger_sel,
  input wire o_probe2_trigger_sel,
  input wire o_push_current_sel,
  input wire [1:0] o_wrap_mode,
  input wire [7:0] o_class_c_value,
  input wire [7:0] o_main_power_mode,
  input wire o_storage_alarm,
  input wire [7:0] o_alarm_code,
  input wire o_nv_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  reg [1:0] rst_hist_q;
  always @(posedge i_core_clk) begin
    rst_hist_q <= {rst_hist_q[0], i_rst};
  end
  // boot: stored values may load in the two samples after reset
  wire boot = |rst_hist_q;
  wire wr = i_req_valid && i_req_write;
  // the two firmware objects share all bits but the last
  wire ro = i_req_index == 16'h1000 || i_req_index == 16'h1001 ||
    i_req_index == 16'h1018 || i_req_index[15:1] == 15'h2321;
  sequence s_loss_mid_commit;
    i_ctrl_supply_loss && o_nv_busy ##1 o_nv_busy;
  endsequence
  a_rsp_next_cycle: assert property (i_req_valid |=> o_rsp_valid)
    else $error("no answer one cycle after a request");
  a_rsp_needs_req: assert property (o_rsp_valid |-> $past(i_req_valid))
    else $error("answer without a request");
  a_ro_write_abort: assert property (wr && ro |=> o_rsp_abort)
    else $error("read-only write not aborted");
  a_sel_range_abort: assert property (
    wr && i_req_index == 16'h44b3 && i_req_wdata > 1 |=> o_rsp_abort)
    else $error("select out of range not aborted");
  a_version_read: assert property (
    i_req_valid && !i_req_write && i_req_index == 16'h4643 &&
    i_req_sub == 8'h00 |=> !o_rsp_abort && o_rsp_rdata == 32'h0000_0100)
    else $error("firmware version read wrong");
  a_class_a_now: assert property (
    wr && i_req_index == 16'h413c && i_req_sub == 8'h00 &&
    i_req_wdata < 2 && !boot |=> o_push_current_sel == $past(i_req_wdata[0]))
    else $error("class A value not applied at once");
  a_probe2_on_perm: assert property (
    !boot && !($past(i_probe_function[8]) &&
    !$past(i_probe_function[8], 2)) |-> $stable(o_probe2_trigger_sel))
    else $error("probe two select moved without permission rise");
  a_probe1_on_perm: assert property (
    !boot && !($past(i_probe_function[0]) &&
    !$past(i_probe_function[0], 2)) |-> $stable(o_probe1_trigger_sel))
    else $error("probe one select moved without permission rise");
  a_class_b_stop: assert property (
    !boot && !$past(i_motion_stopped) |-> $stable(o_wrap_mode))
    else $error("class B value applied during motion");
  a_class_c_cfg: assert property (
    !boot && !$past(i_config_exec) |-> $stable(o_class_c_value))
    else $error("class C value applied without configuration");
  a_class_d_boot: assert property (!boot |-> $stable(o_main_power_mode))
    else $error("class D value applied without power cycle");
  a_alarm_code: assert property (
    o_storage_alarm |-> o_alarm_code == 8'h41 ##1 o_storage_alarm)
    else $error("storage alarm code wrong or not held");
  a_abort_alarm: assert property (
    s_loss_mid_commit |-> ##[0:2] o_storage_alarm)
    else $error("aborted commit raised no alarm");
endmodule // drive_od_checker

bind drive_object_dictionary drive_od_checker drive_od_checker_i (
  .i_core_clk, .i_rst, .i_req_valid, .i_req_write, .i_req_index,
  .i_req_sub, .i_req_wdata, .i_probe_function, .i_motion_stopped,
  .i_config_exec, .i_ctrl_supply_loss, .o_rsp_valid, .o_rsp_abort,
  .o_rsp_rdata, .o_probe1_trigger_sel, .o_probe2_trigger_sel,
  .o_push_current_sel, .o_wrap_mode, .o_class_c_value,
  .o_main_power_mode, .o_storage_alarm, .o_alarm_code, .o_nv_busy
);

/* drive_od_consts.vh */
// object dictionary constants: indices, subindices, reset values, timing
// assumes a 25 MHz core clock; included by the dictionary and its store
`ifndef DRIVE_OD_CONSTS_VH
`define DRIVE_OD_CONSTS_VH

// object indices
`define IDX_DEVICE_PROFILE_TYPE 16'h1000
`define IDX_ERROR_SUMMARY 16'h1001
`define IDX_IDENTITY 16'h1018
`define IDX_RX_MAP 16'h1600
`define IDX_COMMIT_PARAMS 16'h40c9
`define IDX_PUSH_CURRENT_SEL 16'h413c
`define IDX_WRAP_MODE 16'h414f
`define IDX_MAIN_POWER_MODE 16'h41fa
`define IDX_CLASS_C_VALUE 16'h4300
`define IDX_PROBE_ONE_SEL 16'h44b2
`define IDX_PROBE_TWO_SEL 16'h44b3
`define IDX_FIRMWARE_CPU_INDEX 16'h4642
`define IDX_FIRMWARE_VERSION 16'h4643

// subindex limits
`define SUB_IDENTITY_LAST 8'h04
`define SUB_RX_MAP_LAST 8'h10

// reset and initial values
`define IDENTITY_ENTRY_COUNT 32'h0000_0004
`define UNIT_SERIAL 32'h0000_0000
`define RX_MAP_COUNT_RESET 5'h03
`define RX_MAP_ENTRY1_RESET 32'h6040_0010
`define RX_MAP_ENTRY2_RESET 32'h607a_0020
`define RX_MAP_ENTRY3_RESET 32'h6060_0008
`define RX_MAP_ENTRY_REST_RESET 32'h0000_0000
`define MAIN_POWER_AUTO 8'hff

// write ranges
`define RANGE_SEL_MAX 32'h0000_0001
`define RANGE_WRAP_MAX 32'h0000_0003
`define RANGE_BYTE_MAX 32'h0000_00ff
`define RANGE_RX_COUNT_MAX 32'h0000_0010
`define COMMIT_CODE 32'h0000_0001

// storage alarm
`define ALARM_CODE_STORAGE 8'h41
`define ERR_BIT_GENERIC 0

// non-volatile slots
`define NV_SLOTS 6
`define NV_SLOT_PROBE_ONE 0
`define NV_SLOT_PROBE_TWO 1
`define NV_SLOT_PUSH 2
`define NV_SLOT_WRAP 3
`define NV_SLOT_CLASS_C 4
`define NV_SLOT_MAIN_POWER 5

// timing
`define CORE_CLK_HZ 25000000
`define NV_HOLD_S 5
`define NV_HOLD_CYCLES (`NV_HOLD_S * `CORE_CLK_HZ)
`define NV_BYTE_CYCLES 4

`endif

/* fieldbus_master_model.sv */
// fieldbus master model: one dictionary access at a time
// assumes the answer comes within four cycles of the request edge
`timescale 1ns/1ps
module fieldbus_master_model (
  input wire i_core_clk,
  input wire i_rsp_valid,
  input wire i_rsp_abort,
  input wire [31:0] i_rsp_rdata,
  output logic o_req_valid,
  output logic o_req_write,
  output logic [15:0] o_req_index,
  output logic [7:0] o_req_sub,
  output logic [31:0] o_req_wdata
);
  initial begin
    o_req_valid = 1'b0;
    o_req_write = 1'b0;
    o_req_index = 16'h0000;
    o_req_sub = 8'h00;
    o_req_wdata = 32'h0000_0000;
  end
  task access(input logic w, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd,
    output logic ab, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    ab = 1'b1;
    rd = 32'h0000_0000;
    @(posedge i_core_clk);
    o_req_valid <= 1'b1;
    o_req_write <= w;
    o_req_index <= idx;
    o_req_sub <= sub;
    o_req_wdata <= wd;
    @(posedge i_core_clk);
    // released index, sub and data show the inverse, never a stale value; write keeps its value
    o_req_valid <= 1'b0;
    o_req_index <= ~idx;
    o_req_sub <= ~sub;
    o_req_wdata <= ~wd;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rsp_valid === 1'b1) begin
        ok = 1'b1;
        ab = i_rsp_abort;
        rd = i_rsp_rdata;
      end else begin
        @(posedge i_core_clk);
      end
    end
  endtask
endmodule // fieldbus_master_model

/* param_nv_store.v */
// non-volatile parameter store: byte array, batch commit, abort watch
// assumes commit only when idle; contents are not touched by reset
`timescale 1ns/1ps
`include "drive_od_consts.vh"

module param_nv_store #(
  parameter HOLD_CYCLES = `NV_HOLD_CYCLES,
  parameter BYTE_CYCLES = `NV_BYTE_CYCLES
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_commit,
  input wire [8*`NV_SLOTS-1:0] i_ram_bytes,
  input wire i_supply_loss,
  output wire [8*`NV_SLOTS-1:0] o_nv_bytes,
  output wire o_busy,
  output reg o_abort
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WRITE = 2'd1;
  localparam ST_HOLD = 2'd2;

  reg [7:0] nv_mem [0:`NV_SLOTS-1];
  reg [8*`NV_SLOTS-1:0] snap_q;
  reg [1:0] state_q;
  reg [2:0] slot_q;
  reg [31:0] cnt_q;
  integer k;

  // factory contents; retained across reset like real storage
  initial begin
    for (k = 0; k < `NV_SLOTS; k = k + 1)
      nv_mem[k] = 8'h00;
    nv_mem[`NV_SLOT_MAIN_POWER] = `MAIN_POWER_AUTO;
  end

  genvar g;
  generate
    for (g = 0; g < `NV_SLOTS; g = g + 1) begin : g_rd
      assign o_nv_bytes[8*g+7:8*g] = nv_mem[g];
    end
  endgenerate

  assign o_busy = (state_q != ST_IDLE);

  always @(posedge i_core_clk) begin
    if (state_q == ST_WRITE && cnt_q == BYTE_CYCLES - 1 && !i_supply_loss)
      nv_mem[slot_q] <= snap_q[8*slot_q +: 8];
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      slot_q <= 3'd0;
      cnt_q <= 32'h0;
      snap_q <= {8*`NV_SLOTS{1'b0}};
      o_abort <= 1'b0;
    end else begin
      o_abort <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_commit) begin
            snap_q <= i_ram_bytes;
            slot_q <= 3'd0;
            cnt_q <= 32'h0;
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (i_supply_loss) begin
            o_abort <= 1'b1;
            state_q <= ST_IDLE;
          end else if (cnt_q == BYTE_CYCLES - 1) begin
            cnt_q <= 32'h0;
            if (slot_q == `NV_SLOTS - 1)
              state_q <= ST_HOLD;
            else
              slot_q <= slot_q + 3'd1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_HOLD: begin
          // supply loss soon after the write still counts as aborted
          if (i_supply_loss) begin
            o_abort <= 1'b1;
            state_q <= ST_IDLE;
          end else if (cnt_q == HOLD_CYCLES - 1) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // param_nv_store

/* test_drive_object_dictionary.sv */
// testbench: reads, refusals, update classes, persistence, alarm
// assumes the master model issues requests; bench drives the rest
`timescale 1ns/1ps
module test_drive_object_dictionary;
  localparam logic [15:0] CPU = 16'h0007; // arbitrary value
  logic i_core_clk, i_rst, stopped, cfg, loss, ab, ok;
  logic [15:0] probe_fn;
  logic [31:0] rd;
  int errors, samples_checked;
  wire rv, rw, sv, sa, p1, p2, push, alarm, busy;
  wire [15:0] ri;
  wire [7:0] rs, cc, mp, code;
  wire [31:0] rwd, srd;
  wire [1:0] wrap;
  wire [4:0] rxc;
  fieldbus_master_model fieldbus_master_model_i (.i_core_clk(i_core_clk),
    .i_rsp_valid(sv), .i_rsp_abort(sa), .i_rsp_rdata(srd),
    .o_req_valid(rv), .o_req_write(rw), .o_req_index(ri),
    .o_req_sub(rs), .o_req_wdata(rwd));
  drive_object_dictionary #(.FIRMWARE_CPU_INDEX(CPU),
    .NV_HOLD_CYCLES(20), .NV_BYTE_CYCLES(4)) drive_object_dictionary_i (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_req_valid(rv),
    .i_req_write(rw), .i_req_index(ri), .i_req_sub(rs),
    .i_req_wdata(rwd), .i_probe_function(probe_fn),
    .i_motion_stopped(stopped), .i_config_exec(cfg),
    .i_ctrl_supply_loss(loss), .o_rsp_valid(sv), .o_rsp_abort(sa),
    .o_rsp_rdata(srd), .o_probe1_trigger_sel(p1),
    .o_probe2_trigger_sel(p2), .o_push_current_sel(push),
    .o_wrap_mode(wrap), .o_class_c_value(cc), .o_main_power_mode(mp),
    .o_rx_map_count(rxc), .o_storage_alarm(alarm), .o_alarm_code(code),
    .o_nv_busy(busy));
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task summarize;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d);
    fieldbus_master_model_i.access(w, i, s, d, ab, rd, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t no answer", $time);
      summarize();
    end
  endtask
  task rd_(input logic [15:0] i, input logic [7:0] s, input logic a,
    input logic [31:0] e);
    acc(1'b0, i, s, 32'h0);
    chk({31'h0, ab}, {31'h0, a});
    chk(rd, e);
  endtask
  task wr_(input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic a);
    acc(1'b1, i, s, d);
    chk({31'h0, ab}, {31'h0, a});
  endtask
  task do_reset;
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    tick(2);
  endtask
  task wait_idle;
    int n;
    tick(2);
    for (n = 0; n < 200 && busy !== 1'b0; n++) tick(1);
    if (busy !== 1'b0) begin
      errors++;
      $display("BAD %0t store stuck busy", $time);
      summarize();
    end
  endtask
  task t_defaults;
    logic [15:0] ro_idx [5];
    ro_idx = '{16'h1000, 16'h1001, 16'h1018, 16'h4642, 16'h4643};
    rd_(16'h1600, 8'h00, 1'b0, 32'h3);
    rd_(16'h1600, 8'h01, 1'b0, 32'h6040_0010);
    rd_(16'h1600, 8'h02, 1'b0, 32'h607a_0020);
    rd_(16'h1600, 8'h03, 1'b0, 32'h6060_0008);
    rd_(16'h1600, 8'h10, 1'b0, 32'h0);
    rd_(16'h1600, 8'h11, 1'b1, 32'h0);
    rd_(16'h1018, 8'h00, 1'b0, 32'h4);
    rd_(16'h1018, 8'h04, 1'b0, 32'h0);
    rd_(16'h4642, 8'h00, 1'b0, {16'h0, CPU});
    foreach (ro_idx[k]) wr_(ro_idx[k], 8'h00, 32'h1, 1'b1);
    rd_(16'h4643, 8'h00, 1'b0, 32'h0100);
    rd_(16'h1001, 8'h00, 1'b0, 32'h0);
    chk({24'h0, mp}, 32'hff);
    $display("done: defaults");
  endtask
  task t_probe;
    wr_(16'h44b3, 8'h00, 32'h2, 1'b1);
    wr_(16'h44b3, 8'h00, 32'h1, 1'b0);
    tick(3);
    chk({31'h0, p2}, 32'h0);
    probe_fn <= 16'h0100;
    tick(1);
    chk({31'h0, p2}, 32'h1);
    rd_(16'h44b3, 8'h00, 1'b0, 32'h1);
    probe_fn <= 16'h0001;
    wr_(16'h44b2, 8'h00, 32'h1, 1'b0);
    tick(2);
    chk({31'h0, p1}, 32'h0);
    probe_fn <= 16'h0000;
    tick(1);
    probe_fn <= 16'h0001;
    tick(1);
    chk({31'h0, p1}, 32'h1);
    $display("done: probe selects");
  endtask
  task t_classes;
    wr_(16'h413c, 8'h00, 32'h1, 1'b0);
    chk({31'h0, push}, 32'h1);
    wr_(16'h414f, 8'h00, 32'h4, 1'b1);
    wr_(16'h414f, 8'h00, 32'h3, 1'b0);
    tick(3);
    chk({30'h0, wrap}, 32'h0);
    stopped <= 1'b1;
    tick(1);
    chk({30'h0, wrap}, 32'h3);
    wr_(16'h4300, 8'h00, 32'h5a, 1'b0);
    tick(3);
    chk({24'h0, cc}, 32'h0);
    cfg <= 1'b1;
    tick(1);
    cfg <= 1'b0;
    chk({24'h0, cc}, 32'h5a);
    wr_(16'h41fa, 8'h00, 32'h2, 1'b1);
    wr_(16'h41fa, 8'h00, 32'h1, 1'b0);
    tick(3);
    chk({24'h0, mp}, 32'hff);
    wr_(16'h1600, 8'h00, 32'h11, 1'b1);
    wr_(16'h1600, 8'h00, 32'h10, 1'b0);
    tick(2);
    chk({27'h0, rxc}, 32'h10);
    $display("done: update classes");
  endtask
  task t_persist;
    wr_(16'h40c9, 8'h00, 32'h2, 1'b1);
    wr_(16'h40c9, 8'h00, 32'h1, 1'b0);
    wait_idle();
    wr_(16'h41fa, 8'h00, 32'h0, 1'b0);
    do_reset();
    chk({24'h0, mp}, 32'h1);
    chk({24'h0, cc}, 32'h5a);
    chk({30'h0, wrap}, 32'h3);
    chk({31'h0, p2}, 32'h1);
    rd_(16'h1600, 8'h00, 1'b0, 32'h3);
    $display("done: persistence");
  endtask
  task t_alarm;
    wr_(16'h40c9, 8'h00, 32'h1, 1'b0);
    tick(6);
    chk({31'h0, busy}, 32'h1);
    loss <= 1'b1;
    tick(1);
    loss <= 1'b0;
    tick(3);
    chk({31'h0, alarm}, 32'h1);
    chk({24'h0, code}, 32'h41);
    rd_(16'h1001, 8'h00, 1'b0, 32'h1);
    $display("done: storage alarm");
  endtask
  initial begin
    i_rst = 1'b1;
    stopped = 1'b0;
    cfg = 1'b0;
    loss = 1'b0;
    probe_fn = 16'h0000;
    errors = 0;
    samples_checked = 0;
    do_reset();
    t_defaults();
    t_probe();
    t_classes();
    t_persist();
    t_alarm();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    $display("BAD %0t run too long", $time);
    summarize();
  end
endmodule // test_drive_object_dictionary
